// [rtl/afgc_defines.svh]
`ifndef AFGC_DEFINES_SVH
`define AFGC_DEFINES_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define AFGC_ADDR_W          4
`define AFGC_REG_CTRL        4'h0
`define AFGC_REG_TX_GAIN     4'h1
`define AFGC_REG_RX_GAIN     4'h2
`define AFGC_REG_STATUS      4'h3
`define AFGC_REG_IRQ_STATUS  4'h4
`define AFGC_REG_IRQ_MASK    4'h5
`define AFGC_REG_ZC_DELAY    4'h6
`define AFGC_REG_ZC_PERIOD   4'h7

// ctrl field positions
`define AFGC_CTRL_ZC_SEL     0
`define AFGC_CTRL_AGC_EN     1
`define AFGC_CTRL_RST_VAL    32'h0000_0002

// irq bit positions
`define AFGC_IRQ_OVERCURRENT 0
`define AFGC_IRQ_SHUTDOWN    1
`define AFGC_IRQ_RESTORE     2
`define AFGC_IRQ_ZONE        3
`define AFGC_IRQ_READY       4
`define AFGC_IRQ_W           5

// status field positions
`define AFGC_STAT_ZONE_HI    2
`define AFGC_STAT_PA_EN      3
`define AFGC_STAT_READY      4

// ----------------------------------------------------------------------
// gain ranges
// ----------------------------------------------------------------------
`define AFGC_RX_CODE_MAX     4'h8
`define AFGC_RX_CODE_RST     4'h3
`define AFGC_RX_DB_MIN       (-18)
`define AFGC_RX_DB_STEP      6
`define AFGC_TX_GAIN_MAX     5'h1F
`define AFGC_TX_ATTEN_OFS    31

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define AFGC_CLK_HZ          40000000
`define AFGC_STARTUP_MS      60
`define AFGC_STARTUP_CYC     ((`AFGC_CLK_HZ / 1000) * `AFGC_STARTUP_MS)
`define AFGC_RESET_US        1
`define AFGC_RESET_CYC       ((`AFGC_CLK_HZ / 1000000) * `AFGC_RESET_US)
`define AFGC_STEP_US         10
`define AFGC_STEP_CYC        ((`AFGC_CLK_HZ / 1000000) * `AFGC_STEP_US)

`endif

// [rtl/afgc_pkg.sv]
package afgc_pkg;

  typedef enum logic [1:0] {
    AFGC_ST_STARTUP,
    AFGC_ST_RUN,
    AFGC_ST_HOT
  } afgc_mode_t;

  typedef struct packed {
    logic       overcurrent;
    logic       temp_first;
    logic       temp_second;
    logic       temp_third;
    logic       temp_fourth;
    logic       zc_analog;
    logic       zc_digital;
    logic       rx_over;
    logic       rx_under;
  } afgc_flags_t;

  typedef struct packed {
    logic [4:0] irq;
  } afgc_irq_t;

endpackage

// [rtl/afgc_sync.sv]
`timescale 1ns/10ps
`default_nettype none
`include "afgc_defines.svh"

// ----------------------------------------------------------------------
// three-stage input synchroniser with agreement filter
// ----------------------------------------------------------------------
module afgc_sync #(
  parameter int WIDTH = 9
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] out;
  } afgc_sync_state_t;

  afgc_sync_state_t state;
  afgc_sync_state_t next_state;

  always_comb begin
    next_state    = state;
    next_state.s1 = async_in;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    // only stages two and three are compared, never the first
    for (int i = 0; i < WIDTH; i++) begin
      if (state.s2[i] == state.s3[i]) begin
        next_state.out[i] = state.s2[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign sync_out = state.out;

endmodule
`default_nettype wire

// [rtl/afgc_control.sv]
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "afgc_defines.svh"

// Summary of operation
// - receive gain code n stands for an amplifier gain of -18 dB plus 6 dB per code up to 30 dB.
// - an automatic loop raises or lowers the receive gain code to keep the converter in range.
// - transmit amplitude has 32 logarithmic steps from 0 dB at the top to -31 dB at the bottom.
// - the applied transmit attenuation in dB is the transmit gain setting minus 31.
// - while overcurrent is flagged the transmit gain setting drops one step at a time.
// - the power amplifier is shut down when temperature passes the fourth threshold.
// - after shutdown the amplifier stays off until temperature is below the third threshold.
// - temperature is reported as zone 1 to 4 from the first three thresholds.
// - the zero-crossing source is the analog or digital input chosen by a configuration bit.
// - an internal reference locks to the selected zero crossing with a programmable delay.
// - start-up completes 60 ms after reset release before the block is operational.
// - transmit gain settings span 0 to 31 in a five-bit field.
module afgc_control #(
  parameter int STARTUP_CYC = `AFGC_STARTUP_CYC,
  parameter int STEP_CYC    = `AFGC_STEP_CYC,
  parameter int PERIOD_W    = 24
) (
  input  wire logic                    sys_clk,
  input  wire logic                    reset,
  input  wire logic                    active_low_reset_pin,
  input  wire logic                    current_sense_threshold,
  input  wire logic                    temp_threshold_first,
  input  wire logic                    temp_threshold_second,
  input  wire logic                    temp_threshold_third,
  input  wire logic                    temp_threshold_fourth,
  input  wire logic                    zero_cross_analog_in,
  input  wire logic                    zero_cross_digital_in,
  input  wire logic                    rx_level_over,
  input  wire logic                    rx_level_under,
  input  wire logic [`AFGC_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  output logic      [3:0]              rx_gain_code,
  output logic      [4:0]              tx_gain_code,
  output logic                         amplifier_enable,
  output logic      [2:0]              temp_zone,
  output logic                         zc_reference,
  output logic                         ready,
  output logic                         irq
);

  localparam int CNT_W = $clog2(STARTUP_CYC + 1);
  localparam int RST_W = $clog2(`AFGC_RESET_CYC + 1);
  localparam int STP_W = $clog2(STEP_CYC + 1);

  afgc_pkg::afgc_flags_t raw_flags;
  afgc_pkg::afgc_flags_t flags;
  logic                  pin_rst_sync;

  typedef struct packed {
    afgc_pkg::afgc_mode_t  mode;
    logic [CNT_W-1:0]      startup_cnt;
    logic [RST_W-1:0]      low_cnt;
    logic [STP_W-1:0]      step_cnt;
    logic [3:0]            rx_code;
    logic [4:0]            tx_code;
    logic                  pa_en;
    logic [2:0]            zone;
    logic                  zc_sel;
    logic                  agc_en;
    logic                  zc_last;
    logic [PERIOD_W-1:0]   zc_period;
    logic [PERIOD_W-1:0]   zc_phase;
    logic [PERIOD_W-1:0]   zc_delay;
    logic                  zc_ref;
    logic [4:0]            irq_status;
    logic [4:0]            irq_mask;
    logic [31:0]           rdata;
    logic                  irq;
    logic                  rdy;
  } afgc_state_t;

  afgc_state_t state;
  afgc_state_t next_state;

  assign raw_flags = '{
    overcurrent: current_sense_threshold,
    temp_first:  temp_threshold_first,
    temp_second: temp_threshold_second,
    temp_third:  temp_threshold_third,
    temp_fourth: temp_threshold_fourth,
    zc_analog:   zero_cross_analog_in,
    zc_digital:  zero_cross_digital_in,
    rx_over:     rx_level_over,
    rx_under:    rx_level_under
  };

  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  afgc_sync #(
    .WIDTH ($bits(afgc_pkg::afgc_flags_t) + 1)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .async_in ({raw_flags, ~active_low_reset_pin}),
    .sync_out ({flags, pin_rst_sync})
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic [4:0] events;
    logic       zc_sig;
    logic       zc_rise;
    logic [2:0] zone_now;
    logic       step_tick;
    logic       pin_reset;
    events     = '0;
    zc_sig     = 1'b0;
    zc_rise    = 1'b0;
    zone_now   = 3'h1;
    step_tick  = 1'b0;
    pin_reset  = 1'b0;
    next_state = state;

    // pin reset only counts after a long enough low pulse
    if (pin_rst_sync) begin
      if (state.low_cnt != RST_W'(`AFGC_RESET_CYC)) begin
        next_state.low_cnt = state.low_cnt + RST_W'(1);
      end
    end else begin
      next_state.low_cnt = '0;
      pin_reset = (state.low_cnt == RST_W'(`AFGC_RESET_CYC));
    end

    // shared pacing for both gain loops
    if (state.step_cnt == STP_W'(STEP_CYC - 1)) begin
      next_state.step_cnt = '0;
      step_tick = 1'b1;
    end else begin
      next_state.step_cnt = state.step_cnt + STP_W'(1);
    end

    // temperature zone from the lower three thresholds
    if (flags.temp_third) begin
      zone_now = 3'h4;
    end else if (flags.temp_second) begin
      zone_now = 3'h3;
    end else if (flags.temp_first) begin
      zone_now = 3'h2;
    end
    next_state.zone = zone_now;
    events[`AFGC_IRQ_ZONE] = (zone_now != state.zone);

    zc_sig  = state.zc_sel ? flags.zc_digital : flags.zc_analog;
    next_state.zc_last = zc_sig;
    zc_rise = zc_sig & ~state.zc_last;

    // period tracker: phase counter realigns on every rising crossing
    if (zc_rise) begin
      // phase runs 0..period-1, so the crossing cycle itself adds one
      if (state.zc_phase == '1) begin
        next_state.zc_period = state.zc_phase;
      end else begin
        next_state.zc_period = state.zc_phase + PERIOD_W'(1);
      end
      next_state.zc_phase  = '0;
    end else if (state.zc_phase != '1) begin
      next_state.zc_phase = state.zc_phase + PERIOD_W'(1);
    end
    // reference is a square wave shifted by the programmed delay
    next_state.zc_ref = (state.zc_phase >= state.zc_delay) &&
                        (state.zc_phase < state.zc_delay + (state.zc_period >> 1));

    case (state.mode)
      afgc_pkg::AFGC_ST_STARTUP: begin
        next_state.pa_en = 1'b0;
        if (state.startup_cnt == CNT_W'(STARTUP_CYC - 1)) begin
          next_state.mode  = afgc_pkg::AFGC_ST_RUN;
          next_state.pa_en = 1'b1;
          events[`AFGC_IRQ_READY] = 1'b1;
        end else begin
          next_state.startup_cnt = state.startup_cnt + CNT_W'(1);
        end
      end
      afgc_pkg::AFGC_ST_RUN: begin
        if (flags.temp_fourth) begin
          next_state.mode  = afgc_pkg::AFGC_ST_HOT;
          next_state.pa_en = 1'b0;
          events[`AFGC_IRQ_SHUTDOWN] = 1'b1;
        end
      end
      afgc_pkg::AFGC_ST_HOT: begin
        if (!flags.temp_third) begin
          next_state.mode  = afgc_pkg::AFGC_ST_RUN;
          next_state.pa_en = 1'b1;
          events[`AFGC_IRQ_RESTORE] = 1'b1;
        end
      end
      default: begin
        next_state.mode = afgc_pkg::AFGC_ST_STARTUP;
      end
    endcase

    if (state.mode != afgc_pkg::AFGC_ST_STARTUP && step_tick) begin
      // attenuation is tx_code - 31 dB, so one code is one dB step
      if (flags.overcurrent && state.tx_code != 5'h00) begin
        next_state.tx_code = state.tx_code - 5'h01;
        events[`AFGC_IRQ_OVERCURRENT] = 1'b1;
      end
      // gain per code is -18 + 6*code dB; over range lowers, under raises
      if (state.agc_en) begin
        if (flags.rx_over && state.rx_code != 4'h0) begin
          next_state.rx_code = state.rx_code - 4'h1;
        end else if (flags.rx_under && !flags.rx_over &&
                     state.rx_code < `AFGC_RX_CODE_MAX) begin
          next_state.rx_code = state.rx_code + 4'h1;
        end
      end
    end

    // register reads one cycle later; irq status read clears
    next_state.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `AFGC_REG_CTRL: begin
          next_state.rdata[`AFGC_CTRL_ZC_SEL] = state.zc_sel;
          next_state.rdata[`AFGC_CTRL_AGC_EN] = state.agc_en;
        end
        `AFGC_REG_TX_GAIN:    next_state.rdata[4:0] = state.tx_code;
        `AFGC_REG_RX_GAIN:    next_state.rdata[3:0] = state.rx_code;
        `AFGC_REG_STATUS: begin
          next_state.rdata[`AFGC_STAT_ZONE_HI:0] = state.zone;
          next_state.rdata[`AFGC_STAT_PA_EN]     = state.pa_en;
          next_state.rdata[`AFGC_STAT_READY]     = state.rdy;
        end
        `AFGC_REG_IRQ_STATUS: begin
          next_state.rdata[4:0] = state.irq_status;
          next_state.irq_status = '0;
        end
        `AFGC_REG_IRQ_MASK:   next_state.rdata[4:0] = state.irq_mask;
        `AFGC_REG_ZC_DELAY:   next_state.rdata[PERIOD_W-1:0] = state.zc_delay;
        `AFGC_REG_ZC_PERIOD:  next_state.rdata[PERIOD_W-1:0] = state.zc_period;
        default:              next_state.rdata = '0;
      endcase
    end
    if (reg_wr) begin
      case (reg_addr)
        `AFGC_REG_CTRL: begin
          next_state.zc_sel = reg_wdata[`AFGC_CTRL_ZC_SEL];
          next_state.agc_en = reg_wdata[`AFGC_CTRL_AGC_EN];
        end
        // writes outside 0..31 cannot occur in a five-bit field
        `AFGC_REG_TX_GAIN: next_state.tx_code = reg_wdata[4:0];
        `AFGC_REG_RX_GAIN: begin
          if (reg_wdata[3:0] > `AFGC_RX_CODE_MAX) begin
            next_state.rx_code = `AFGC_RX_CODE_MAX;
          end else begin
            next_state.rx_code = reg_wdata[3:0];
          end
        end
        `AFGC_REG_IRQ_MASK: next_state.irq_mask = reg_wdata[4:0];
        `AFGC_REG_ZC_DELAY: next_state.zc_delay = reg_wdata[PERIOD_W-1:0];
        default: begin
        end
      endcase
    end

    // new events win over the read-clear
    next_state.irq_status = next_state.irq_status | events;
    next_state.irq        = |(next_state.irq_status & next_state.irq_mask);

    if (pin_reset) begin
      next_state.mode        = afgc_pkg::AFGC_ST_STARTUP;
      next_state.startup_cnt = '0;
      next_state.pa_en       = 1'b0;
    end

    // kept in a flop so the ready pin is not decoded from the mode
    next_state.rdy = (next_state.mode != afgc_pkg::AFGC_ST_STARTUP);
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state         <= '0;
      state.mode    <= afgc_pkg::AFGC_ST_STARTUP;
      state.rx_code <= `AFGC_RX_CODE_RST;
      state.tx_code <= `AFGC_TX_GAIN_MAX;
      state.zone    <= 3'h1;
      state.agc_en  <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign reg_rdata        = state.rdata;
  assign rx_gain_code     = state.rx_code;
  assign tx_gain_code     = state.tx_code;
  assign amplifier_enable = state.pa_en;
  assign temp_zone        = state.zone;
  assign zc_reference     = state.zc_ref;
  assign ready            = state.rdy;
  assign irq              = state.irq;

endmodule
`default_nettype wire

// [tb/afgc_mains_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// mains zero-crossing source and coupling current sense
// ----------------------------------------------------------------------
module afgc_mains_model #(
  parameter int DIG_PERIOD = 40,
  parameter int ANA_PERIOD = 60
) (
  input  wire logic sys_clk,
  input  wire logic overload,
  output logic      zero_cross_analog_in,
  output logic      zero_cross_digital_in,
  output logic      current_sense_threshold
);
  int dig_ph = 0;
  int ana_ph = 0;
  // mains runs free, so both sources toggle with or without traffic
  always @(posedge sys_clk) begin
    dig_ph <= (dig_ph + 1) % DIG_PERIOD;
    ana_ph <= (ana_ph + 1) % ANA_PERIOD;
  end
  assign zero_cross_digital_in   = dig_ph < DIG_PERIOD / 2;
  assign zero_cross_analog_in    = ana_ph < ANA_PERIOD / 2;
  assign current_sense_threshold = overload;
endmodule

`default_nettype wire

// [tb/afgc_control_properties.sv]
`timescale 1ns/10ps
`default_nettype none

module afgc_control_properties #(
  parameter int STARTUP_CYC = 50,
  parameter int STEP_CYC    = 4
) (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       active_low_reset_pin,
  input wire logic       temp_threshold_first,
  input wire logic       temp_threshold_second,
  input wire logic       temp_threshold_third,
  input wire logic       temp_threshold_fourth,
  input wire logic       reg_wr,
  input wire logic [3:0] rx_gain_code,
  input wire logic [4:0] tx_gain_code,
  input wire logic       amplifier_enable,
  input wire logic [2:0] temp_zone,
  input wire logic       ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  int unsigned boot_cnt;
  // tolerance covers the pin synchroniser delay
  always_ff @(posedge sys_clk) begin
    if (reset || !active_low_reset_pin || ready) boot_cnt <= 0;
    else boot_cnt <= boot_cnt + 1;
  end
  a_rx_code_range: assert property (rx_gain_code <= 4'h8)
    else $error("rx gain code above eight");
  a_tx_step_down: assert property ($changed(tx_gain_code) && !$past(reg_wr)
    |-> tx_gain_code == $past(tx_gain_code) - 5'h01) else $error("tx gain jumped");
  a_rx_single_step: assert property ($changed(rx_gain_code) && !$past(reg_wr)
    |-> rx_gain_code == $past(rx_gain_code) + 4'h1 || rx_gain_code == $past(rx_gain_code) - 4'h1)
    else $error("rx gain jumped");
  a_zone_range: assert property (temp_zone inside {[3'h1:3'h4]})
    else $error("zone out of range");
  a_hot_pa_off: assert property (temp_threshold_fourth[*8] |-> !amplifier_enable)
    else $error("amplifier on while hot");
  a_pa_stays_off: assert property (temp_threshold_third[*8] |-> !$rose(amplifier_enable))
    else $error("amplifier restored while warm");
  a_zone_map: assert property (
    $stable({temp_threshold_third, temp_threshold_second, temp_threshold_first})[*8]
    |-> temp_zone == (temp_threshold_third ? 3'h4 : temp_threshold_second ? 3'h3 :
                      temp_threshold_first ? 3'h2 : 3'h1)) else $error("zone mismatch");
  a_boot_length: assert property ($rose(ready)
    |-> boot_cnt + 2 >= STARTUP_CYC && boot_cnt <= STARTUP_CYC + 8)
    else $error("start-up length wrong");
  c_tx_step: cover property ($fell(tx_gain_code[0]) && !$past(reg_wr));
  c_shutdown: cover property ($fell(amplifier_enable));
  c_ready: cover property ($rose(ready));
endmodule

`default_nettype wire

// [tb/afgc_control_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module afgc_control_tb;
  localparam int BOOT = 50;
  localparam int STEP = 4;
  logic        sys_clk   = 1'b0;
  logic        reset     = 1'b1;
  logic        pin_n     = 1'b1;
  logic        overload  = 1'b0;
  logic [3:0]  temp_hot  = 4'h0;
  logic        rx_over   = 1'b0;
  logic        rx_under  = 1'b0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [31:0] reg_rdata, rdv;
  logic [3:0]  rx_gain_code;
  logic [4:0]  tx_gain_code;
  logic [2:0]  temp_zone;
  logic        amplifier_enable, zc_reference, ready, irq, zc_a, zc_d, cur_sense;
  int          err_total = 0;
  int          comparisons = 0;

  always #12.5 sys_clk = ~sys_clk;

  afgc_mains_model mains (.sys_clk(sys_clk), .overload(overload), .zero_cross_analog_in(zc_a),
    .zero_cross_digital_in(zc_d), .current_sense_threshold(cur_sense));

  afgc_control #(.STARTUP_CYC(BOOT), .STEP_CYC(STEP)) dut (.sys_clk(sys_clk), .reset(reset),
    .active_low_reset_pin(pin_n), .current_sense_threshold(cur_sense),
    .temp_threshold_first(temp_hot[0]), .temp_threshold_second(temp_hot[1]),
    .temp_threshold_third(temp_hot[2]), .temp_threshold_fourth(temp_hot[3]),
    .zero_cross_analog_in(zc_a), .zero_cross_digital_in(zc_d), .rx_level_over(rx_over),
    .rx_level_under(rx_under), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_gain_code(rx_gain_code),
    .tx_gain_code(tx_gain_code), .amplifier_enable(amplifier_enable), .temp_zone(temp_zone),
    .zc_reference(zc_reference), .ready(ready), .irq(irq));

  task automatic conclude;
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic give_up(input logic ok);
    if (!ok) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic s_boot;
    int n;
    chk("tx_rst", tx_gain_code, 32'h1F);
    chk("zone_rst", temp_zone, 32'h1);
    chk("rx_rst", rx_gain_code, 32'h3);
    rd(4'h0);
    chk("ctrl_rst", rdv, 32'h2);
    rd(4'hF);
    chk("unmapped", rdv, 32'h0);
    for (n = 4; n < BOOT + 20 && ready !== 1'b1; n++) @(posedge sys_clk);
    give_up(n < BOOT + 20);
    // n counts edges since release; ready is read before the edge updates it
    chk("boot_len", n, BOOT + 1);
  endtask
  task automatic s_irq;
    wr(4'h5, 32'h0);
    cycles(2);
    chk("irq_masked", irq, 32'h0);
    wr(4'h5, 32'h10);
    cycles(2);
    chk("irq_raised", irq, 32'h1);
    rd(4'h4);
    chk("irq_ready", rdv[4], 32'h1);
    cycles(2);
    chk("irq_cleared", irq, 32'h0);
    wr(4'h5, 32'h0);
  endtask
  task automatic s_rx;
    wr(4'h0, 32'h0);
    for (int c = 0; c < 10; c++) begin
      wr(4'h2, c);
      rd(4'h2);
      chk("rx_code", rdv, c > 8 ? 8 : c);
      chk("rx_port", rx_gain_code, c > 8 ? 8 : c);
    end
  endtask
  task automatic s_agc;
    wr(4'h2, 32'h6);
    wr(4'h0, 32'h2);
    rx_under <= 1'b1;
    cycles(12 * STEP);
    chk("agc_up", rx_gain_code, 32'h8);
    rx_under <= 1'b0;
    rx_over  <= 1'b1;
    cycles(14 * STEP);
    chk("agc_floor", rx_gain_code, 32'h0);
    rx_over <= 1'b0;
    wr(4'h0, 32'h0);
  endtask
  task automatic s_tx;
    for (int v = 0; v < 32; v += 31) begin
      wr(4'h1, v);
      rd(4'h1);
      chk("tx_range", rdv, v);
    end
    wr(4'h1, 32'h2);
    wr(4'h5, 32'h1);
    overload <= 1'b1;
    cycles(12 * STEP);
    chk("tx_floor", tx_gain_code, 32'h0);
    chk("irq_oc", irq, 32'h1);
    overload <= 1'b0;
    cycles(3 * STEP);
    rd(4'h4);
    chk("oc_status", rdv[0], 32'h1);
    wr(4'h5, 32'h0);
    wr(4'h1, 32'h9);
    cycles(10 * STEP);
    chk("tx_hold", tx_gain_code, 32'h9);
    chk("atten_db", 32'(int'(tx_gain_code) - 31), -32'sd22);
  endtask
  task automatic s_therm;
    for (int k = 0; k < 4; k++) begin
      temp_hot <= 4'((1 << k) - 1);
      cycles(10);
      chk("zone", temp_zone, k + 1);
    end
    chk("pa_run", amplifier_enable, 32'h1);
    temp_hot <= 4'hF;
    cycles(10);
    chk("pa_shut", amplifier_enable, 32'h0);
    temp_hot <= 4'h7;
    cycles(10);
    chk("pa_held", amplifier_enable, 32'h0);
    temp_hot <= 4'h3;
    cycles(10);
    chk("pa_back", amplifier_enable, 32'h1);
    temp_hot <= 4'h0;
    cycles(10);
  endtask
  task automatic s_zc;
    int n;
    wr(4'h0, 32'h1);
    cycles(160);
    rd(4'h7);
    chk("zc_dig", rdv, 32'd40);
    wr(4'h6, 32'h7);
    cycles(160);
    n = 0;
    repeat (160) begin
      @(posedge sys_clk);
      n += zc_reference;
    end
    chk("zc_duty", n, 32'd80);
    wr(4'h0, 32'h0);
    cycles(240);
    rd(4'h7);
    chk("zc_ana", rdv, 32'd60);
  endtask
  task automatic s_pin;
    int n;
    pin_n <= 1'b0;
    cycles(10);
    pin_n <= 1'b1;
    cycles(10);
    chk("short_pin", ready, 32'h1);
    pin_n <= 1'b0;
    cycles(45);
    pin_n <= 1'b1;
    cycles(10);
    chk("pin_boot", ready, 32'h0);
    chk("pin_keep", tx_gain_code, 32'h9);
    for (n = 0; n < BOOT + 20 && ready !== 1'b1; n++) @(posedge sys_clk);
    give_up(n < BOOT + 20);
  endtask

  initial begin
    cycles(20);
    reset <= 1'b0;
    s_boot();
    s_irq();
    s_rx();
    s_agc();
    s_tx();
    s_therm();
    s_zc();
    s_pin();
    conclude();
  end
endmodule

bind afgc_control afgc_control_properties #(.STARTUP_CYC(STARTUP_CYC), .STEP_CYC(STEP_CYC))
  props (.sys_clk(sys_clk), .reset(reset), .active_low_reset_pin(active_low_reset_pin),
  .temp_threshold_first(temp_threshold_first), .temp_threshold_second(temp_threshold_second),
  .temp_threshold_third(temp_threshold_third), .temp_threshold_fourth(temp_threshold_fourth),
  .reg_wr(reg_wr), .rx_gain_code(rx_gain_code), .tx_gain_code(tx_gain_code),
  .amplifier_enable(amplifier_enable), .temp_zone(temp_zone), .ready(ready));

`default_nettype wire
